/* File: design/bpp_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module bpp_sync #(
	parameter int W = 1
) (
	clk_sys,
	resetn,
	din,
	dout
);
	input wire logic clk_sys;
	input wire logic resetn;
	input wire logic [W-1:0] din;
	output logic [W-1:0] dout;

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// s1 feeds only s2; metastability stays off the compare
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					s1_q[i] <= 1'b0;
					s2_q[i] <= 1'b0;
					s3_q[i] <= 1'b0;
					dout[i] <= 1'b0;
				end else begin
					s1_q[i] <= din[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					if (s2_q[i] == s3_q[i]) begin
						dout[i] <= s3_q[i];
					end
				end
			end
		end
	endgenerate
endmodule : bpp_sync

/* File: design/bpp_top.sv */
// bidirectional printer port: registers, pins and interrupt
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "bpp_defines.svh"

module bpp_top
	import bpp_pkg::*;
(
	clk_sys,
	resetn,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	periph_in,
	periph_out,
	port_data_bits_in,
	port_data_bits_out,
	port_data_bits_oe,
	irq
);
	input wire logic clk_sys;
	input wire logic resetn;
	input wire logic [`BPP_AW-1:0] reg_addr;
	input wire logic [`BPP_DW-1:0] reg_wdata;
	input wire logic reg_wr;
	input wire logic reg_rd;
	output logic [`BPP_DW-1:0] reg_rdata;
	input wire bpp_periph_in_t periph_in;
	output bpp_periph_out_t periph_out;
	input wire logic [`BPP_DW-1:0] port_data_bits_in;
	output logic [`BPP_DW-1:0] port_data_bits_out;
	output logic [`BPP_DW-1:0] port_data_bits_oe;
	output logic irq;

	// synchronised pin levels
	logic [`BPP_NSYNC-1:0] sync_in;
	logic [`BPP_NSYNC-1:0] sync_out;
	bpp_periph_in_t pin_s;
	logic [`BPP_DW-1:0] data_s;

	// software state
	logic [`BPP_DW-1:0] data_q;
	bpp_control_t ctrl_q;
	logic [`BPP_NEV-1:0] irq_stat_q;
	logic [`BPP_NEV-1:0] irq_stat_d;
	logic [`BPP_NEV-1:0] irq_mask_q;
	logic mode_printer_q;

	// event detection
	logic ack_prev_q;
	logic err_prev_q;
	logic ack_rise;
	logic err_fall;
	logic [`BPP_NEV-1:0] ev;

	// decode
	logic wr_data;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic wr_mode;
	logic input_mode;

	// read path
	bpp_status_t status_view;
	logic [`BPP_DW-1:0] rdata_d;

	assign sync_in = {periph_in, port_data_bits_in};

	// every pin input crosses in through three stages
	bpp_sync #(
		.W(`BPP_NSYNC)
	) u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.din(sync_in),
		.dout(sync_out)
	);

	assign pin_s = sync_out[`BPP_NSYNC-1:`BPP_DW];
	assign data_s = sync_out[`BPP_DW-1:0];

	always_comb begin
		wr_data = reg_wr && (reg_addr == `BPP_OFS_DATA);
		wr_ctrl = reg_wr && (reg_addr == `BPP_OFS_CONTROL);
		wr_stat = reg_wr && (reg_addr == `BPP_OFS_IRQ_STAT);
		wr_mask = reg_wr && (reg_addr == `BPP_OFS_IRQ_MASK);
		wr_mode = reg_wr && (reg_addr == `BPP_OFS_MODE);
	end

	// input mode only outside output-only printer mode
	assign input_mode = ctrl_q.data_direction_bit && !mode_printer_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			data_q <= `BPP_RST_DATA;
		end else if (wr_data) begin
			// latched even in input mode, driven once direction flips
			data_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= `BPP_RST_CONTROL;
		end else if (wr_ctrl) begin
			// bits 6 and 7 are fixed ones and not stored
			ctrl_q <= reg_wdata[`BPP_DW-3:0];
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_printer_q <= `BPP_RST_MODE;
		end else if (wr_mode) begin
			mode_printer_q <= reg_wdata[`BPP_MODE_PRINTER];
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_mask_q <= `BPP_RST_IRQ_MASK;
		end else if (wr_mask) begin
			irq_mask_q <= reg_wdata[`BPP_NEV-1:0];
		end
	end

	// edge history on the filtered levels, never on raw pins
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ack_prev_q <= 1'b0;
			err_prev_q <= 1'b0;
		end else begin
			ack_prev_q <= pin_s.ack_n;
			err_prev_q <= pin_s.err_n;
		end
	end

	// positive-going acknowledge ends a character handshake
	assign ack_rise = pin_s.ack_n && !ack_prev_q;
	assign err_fall = !pin_s.err_n && err_prev_q;

	always_comb begin
		ev = '0;
		ev[`BPP_EV_ACK] = ack_rise && ctrl_q.irq_enable_bit;
		ev[`BPP_EV_ERR] = err_fall;
	end

	// write-one-to-clear; a same-cycle event wins over the clear
	always_comb begin
		irq_stat_d = irq_stat_q;
		if (wr_stat) begin
			irq_stat_d = irq_stat_d & ~reg_wdata[`BPP_NEV-1:0];
		end
		irq_stat_d = irq_stat_d | ev;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_stat_q <= `BPP_RST_IRQ_STAT;
		end else begin
			irq_stat_q <= irq_stat_d;
		end
	end

	// level request on the port's single fixed line
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_d & irq_mask_q);
		end
	end

	// handshake outputs take one flop stage after the control register, two cycles after the write
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			periph_out.strobe_n <= 1'b1;
			periph_out.line_feed_auto_n <= 1'b1;
			periph_out.init <= 1'b0;
			periph_out.peripheral_select <= 1'b1;
		end else begin
			periph_out.strobe_n <= !ctrl_q.strobe;
			periph_out.line_feed_auto_n <= !ctrl_q.auto_feed;
			periph_out.init <= ctrl_q.init;
			periph_out.peripheral_select <= !ctrl_q.peripheral_select;
		end
	end

	// data drivers; enable follows direction with one flop of latency
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			port_data_bits_out <= `BPP_RST_DATA;
			port_data_bits_oe <= {`BPP_DW{1'b1}};
		end else begin
			port_data_bits_out <= data_q;
			port_data_bits_oe <= {`BPP_DW{!input_mode}};
		end
	end

	always_comb begin
		status_view.busy_n = !pin_s.busy;
		status_view.ack_n = pin_s.ack_n;
		status_view.paper_out_status = pin_s.paper_out;
		status_view.online_status = pin_s.online;
		status_view.err_n = pin_s.err_n;
		status_view.zero = `BPP_ST_ZERO;
	end

	// unmapped offsets read as zero
	always_comb begin
		rdata_d = `BPP_ZERO8;
		case (reg_addr)
			`BPP_OFS_DATA: begin
				rdata_d = input_mode ? data_s : data_q;
			end
			`BPP_OFS_STATUS: begin
				rdata_d = status_view;
			end
			`BPP_OFS_CONTROL: begin
				rdata_d = {`BPP_CTL_FIXED, ctrl_q};
			end
			`BPP_OFS_IRQ_STAT: begin
				rdata_d = {`BPP_PAD_EV, irq_stat_q};
			end
			`BPP_OFS_IRQ_MASK: begin
				rdata_d = {`BPP_PAD_EV, irq_mask_q};
			end
			`BPP_OFS_MODE: begin
				rdata_d = {`BPP_PAD_MODE, mode_printer_q};
			end
			default: begin
				rdata_d = `BPP_ZERO8;
			end
		endcase
	end

	// data valid only the cycle after the read strobe, zero otherwise
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= `BPP_ZERO8;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= `BPP_ZERO8;
		end
	end
endmodule : bpp_top

/* File: pkg/bpp_defines.svh */
// offsets, reset values and field constants of the printer port
`ifndef BPP_DEFINES_SVH
`define BPP_DEFINES_SVH
`define BPP_DW 8
`define BPP_AW 3
`define BPP_NSYNC 13
`define BPP_OFS_DATA 3'h0
`define BPP_OFS_STATUS 3'h1
`define BPP_OFS_CONTROL 3'h2
`define BPP_OFS_IRQ_STAT 3'h3
`define BPP_OFS_IRQ_MASK 3'h4
`define BPP_OFS_MODE 3'h5
`define BPP_RST_DATA 8'h00
`define BPP_RST_CONTROL 6'h00
`define BPP_CTL_FIXED 2'h3
`define BPP_ST_ZERO 3'h0
`define BPP_RST_IRQ_STAT 2'h0
`define BPP_RST_IRQ_MASK 2'h3
`define BPP_RST_MODE 1'h0
`define BPP_EV_ACK 0
`define BPP_EV_ERR 1
`define BPP_NEV 2
`define BPP_PAD_EV 6'h00
`define BPP_PAD_MODE 7'h00
`define BPP_MODE_PRINTER 0
`define BPP_ZERO8 8'h00
`endif

/* File: pkg/bpp_pkg.sv */
// types shared by the printer port design
`include "bpp_defines.svh"
package bpp_pkg;
	typedef struct packed {
		logic err_n;
		logic online;
		logic paper_out;
		logic ack_n;
		logic busy;
	} bpp_periph_in_t;

	typedef struct packed {
		logic strobe_n;
		logic line_feed_auto_n;
		logic init;
		logic peripheral_select;
	} bpp_periph_out_t;

	typedef struct packed {
		logic busy_n;
		logic ack_n;
		logic paper_out_status;
		logic online_status;
		logic err_n;
		logic [2:0] zero;
	} bpp_status_t;

	typedef struct packed {
		logic data_direction_bit;
		logic irq_enable_bit;
		logic peripheral_select;
		logic init;
		logic auto_feed;
		logic strobe;
	} bpp_control_t;
endpackage : bpp_pkg

/* File: testbench/bpp_checker.sv */
// assertions on the printer port pins and register port
`timescale 1ns/1ps
`include "bpp_defines.svh"
module bpp_checker
	import bpp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [`BPP_AW-1:0] reg_addr,
	input wire logic [`BPP_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [`BPP_DW-1:0] reg_rdata,
	input wire bpp_periph_in_t periph_in,
	input wire bpp_periph_out_t periph_out,
	input wire logic [`BPP_DW-1:0] port_data_bits_oe
);
	logic [2:0] calm_q;
	bpp_periph_in_t pin_q;
	logic ctl_wr;
	logic st_rd;
	// status compares only once pins sat still past the synchroniser
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			calm_q <= 3'h0;
			pin_q <= '0;
		end else begin
			pin_q <= periph_in;
			if (periph_in != pin_q)
				calm_q <= 3'h0;
			else if (calm_q != 3'h7)
				calm_q <= calm_q + 3'h1;
		end
	end
	assign ctl_wr = reg_wr && reg_addr == `BPP_OFS_CONTROL;
	assign st_rd = reg_rd && reg_addr == `BPP_OFS_STATUS && calm_q == 3'h7;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_strobe_pin: assert property (
		ctl_wr |-> ##2 periph_out.strobe_n == !$past(reg_wdata[0], 2))
		else $error("strobe pin");
	a_feed_pin: assert property (
		ctl_wr |-> ##2 periph_out.line_feed_auto_n == !$past(reg_wdata[1], 2))
		else $error("feed pin");
	a_init_pin: assert property (
		ctl_wr |-> ##2 periph_out.init == $past(reg_wdata[2], 2))
		else $error("init pin");
	a_select_pin: assert property (
		ctl_wr |-> ##2 periph_out.peripheral_select == !$past(reg_wdata[3], 2))
		else $error("select pin");
	a_oe_uniform: assert property (
		port_data_bits_oe == 8'h00 || port_data_bits_oe == 8'hFF)
		else $error("oe split");
	a_err_status: assert property (
		st_rd |=> reg_rdata[3] == $past(periph_in.err_n))
		else $error("err bit");
	a_flag_status: assert property (
		st_rd |=> {reg_rdata[4], reg_rdata[5], reg_rdata[6]}
			== $past(periph_in[3:1]))
		else $error("flag bits");
	a_busy_status: assert property (
		st_rd |=> reg_rdata[7] == !$past(periph_in.busy))
		else $error("busy bit");
endmodule : bpp_checker
bind bpp_top bpp_checker u_chk (.clk_sys(clk_sys), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_in(periph_in),
	.periph_out(periph_out), .port_data_bits_oe(port_data_bits_oe));

/* File: testbench/bpp_periph_model.sv */
// behavioural peripheral on the far side of the printer port
`timescale 1ns/1ps
module bpp_periph_model
	import bpp_pkg::*;
(
	input wire logic [4:0] lvl,
	input wire logic [7:0] far_data,
	input wire logic [7:0] dout,
	input wire logic [7:0] oe,
	output bpp_periph_in_t periph_in,
	output logic [7:0] din
);
	// static levels, held long enough to pass the synchroniser
	assign periph_in = lvl;
	// wire level: port wins where enabled, else peripheral drives
	assign din = (oe & dout) | (~oe & far_data);
endmodule : bpp_periph_model

/* File: testbench/bpp_top_tb.sv */
// self-checking bench of the printer port
`timescale 1ns/1ps
`include "bpp_defines.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module bpp_top_tb
	import bpp_pkg::*;
();
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	bpp_periph_in_t pin;
	bpp_periph_out_t pout;
	logic [7:0] pd_in;
	logic [7:0] pd_out;
	logic [7:0] pd_oe;
	logic irq;
	logic [4:0] lvl = 5'h1A;
	logic [7:0] rv;
	logic [4:0] tbl [4] = '{5'h00, 5'h1F, 5'h15, 5'h0A};
	int err_total = 0;
	int checked = 0;
	int cyc = 0;
	bpp_top dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .periph_in(pin), .periph_out(pout),
		.port_data_bits_in(pd_in), .port_data_bits_out(pd_out),
		.port_data_bits_oe(pd_oe), .irq(irq));
	bpp_periph_model far (.lvl(lvl), .far_data(8'h3C), .dout(pd_out),
		.oe(pd_oe), .periph_in(pin), .din(pd_in));
	task automatic finish_test();
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wait_n
	task automatic pulse_ack();
		@(posedge clk_sys);
		lvl[1] <= 1'b0;
		wait_n(10);
		@(posedge clk_sys);
		lvl[1] <= 1'b1;
		wait_n(10);
	endtask : pulse_ack
	task automatic t_reset();
		`CHK(pout, 4'hD)
		`CHK(pd_oe, 8'hFF)
		`CHK(irq, 1'b0)
		rd(`BPP_OFS_CONTROL, rv);
		`CHK(rv, 8'hC0)
	endtask : t_reset
	task automatic t_ctrl();
		for (int v = 0; v < 16; v++) begin
			wr(`BPP_OFS_CONTROL, 8'(v));
			wait_n(2);
			`CHK(pout, {~v[0], ~v[1], v[2], ~v[3]})
			rd(`BPP_OFS_CONTROL, rv);
			`CHK(rv, 8'hC0 | 8'(v))
		end
	endtask : t_ctrl
	task automatic t_status();
		foreach (tbl[i]) begin
			@(posedge clk_sys);
			lvl <= tbl[i];
			wait_n(10);
			rd(`BPP_OFS_STATUS, rv);
			`CHK(rv, {~tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3], tbl[i][4], 3'h0})
		end
		wr(`BPP_OFS_STATUS, 8'hFF);
		rd(`BPP_OFS_STATUS, rv);
		`CHK(rv, 8'hD0)
		@(posedge clk_sys);
		lvl <= 5'h1A;
		wait_n(10);
	endtask : t_status
	task automatic t_dir();
		wr(`BPP_OFS_DATA, 8'hA5);
		wr(`BPP_OFS_CONTROL, 8'h20);
		wait_n(2);
		`CHK(pd_oe, 8'h00)
		wait_n(6);
		rd(`BPP_OFS_DATA, rv);
		`CHK(rv, 8'h3C)
		wr(`BPP_OFS_MODE, 8'h01);
		wait_n(3);
		`CHK(pd_oe, 8'hFF)
		`CHK(pd_out, 8'hA5)
		wr(`BPP_OFS_MODE, 8'h00);
		wr(`BPP_OFS_CONTROL, 8'h00);
		wait_n(2);
		rd(`BPP_OFS_DATA, rv);
		`CHK(rv, 8'hA5)
		rd(3'h6, rv);
		`CHK(rv, 8'h00)
	endtask : t_dir
	task automatic t_irq();
		wr(`BPP_OFS_IRQ_STAT, 8'h03);
		wr(`BPP_OFS_IRQ_MASK, 8'h01);
		wr(`BPP_OFS_CONTROL, 8'h10);
		pulse_ack();
		`CHK(irq, 1'b1)
		wr(`BPP_OFS_IRQ_STAT, 8'h01);
		wait_n(2);
		`CHK(irq, 1'b0)
		wr(`BPP_OFS_CONTROL, 8'h00);
		pulse_ack();
		rd(`BPP_OFS_IRQ_STAT, rv);
		`CHK(rv[0], 1'b0)
		wr(`BPP_OFS_CONTROL, 8'h10);
		wr(`BPP_OFS_IRQ_MASK, 8'h00);
		pulse_ack();
		`CHK(irq, 1'b0)
		rd(`BPP_OFS_IRQ_STAT, rv);
		`CHK(rv[0], 1'b1)
	endtask : t_irq
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	// whole run needs well under two thousand cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			finish_test();
		end
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		wait_n(1);
		t_reset();
		t_ctrl();
		t_status();
		t_dir();
		t_irq();
		finish_test();
	end
endmodule : bpp_top_tb
